// ===== rtl/dclsd_consts.vh
/*
  Constants for the decade counter, latch and segment decoder.
  Assumes inclusion by rtl/dclsd_top.v only.
*/
`ifndef DCLSD_CONSTS_VH
`define DCLSD_CONSTS_VH
`define DCLSD_DIGIT_W 4
`define DCLSD_SEG_W 7
`define DCLSD_ZERO 4'h0
`define DCLSD_NINE 4'h9
`define DCLSD_BLANK 4'hf
`define DCLSD_SEG_ALL_ON 7'h00
`define DCLSD_SEG_ALL_OFF 7'h7f
`define DCLSD_WB_CTRL 4'h0
`define DCLSD_WB_STAT 4'h4
`define DCLSD_CTRL_W 3
`define DCLSD_ONE 4'h1
`define DCLSD_SEG_D0 7'h40
`define DCLSD_SEG_D1 7'h79
`define DCLSD_SEG_D2 7'h24
`define DCLSD_SEG_D3 7'h30
`define DCLSD_SEG_D4 7'h19
`define DCLSD_SEG_D5 7'h12
`define DCLSD_SEG_D6 7'h02
`define DCLSD_SEG_D7 7'h78
`define DCLSD_SEG_D8 7'h00
`define DCLSD_SEG_D9 7'h10
`define DCLSD_PIN_W 4
`define DCLSD_PIN_CLK 0
`define DCLSD_PIN_EN_N 1
`define DCLSD_PIN_CLR 2
`define DCLSD_PIN_STB 3
`define DCLSD_SYNC_RST 4'h0
`define DCLSD_CTRL_CHECK 0
`define DCLSD_CTRL_BLANK 1
`define DCLSD_CTRL_RST 3'h0
`define DCLSD_SEL_CTRL 0
`define DCLSD_WB_DW 32
`define DCLSD_DAT_RST 32'h0
`define DCLSD_STAT_PAD 23
`endif

// ===== rtl/dclsd_top.v
/*
  Decade counter feeding a four-bit latch and a seven-segment decoder.
  Assumes count_clk, count_enable_n, counter_clear and latch_strobe come from
  pins outside clk_sys; lamp_check and lamp_blank arrive through Wishbone.
*/
`timescale 1ns/100ps
`include "dclsd_consts.vh"
module dclsd_top (
  input wire clk_sys, // System clock, 250 MHz
  input wire rst, // Synchronous reset, high
  input wire ce, // Clock enable, freezes state when low
  input wire count_clk, // Counting clock pin
  input wire count_enable_n, // Count enable pin, low counts
  input wire counter_clear, // Counter clear pin, high
  input wire latch_strobe, // Latch strobe pin, high passes
  output reg [6:0] seg_n, // Segments a..g in bits 0..6, low lit
  output reg terminal_count_flag, // High at count nine
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [3:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o // Wishbone acknowledge
);

  // ----------------------------------------
  // Segment pattern, active low, bit0 = a
  // ----------------------------------------
  function [6:0] seg_of;
    input [3:0] d;
    begin
      case (d)
        `DCLSD_ZERO: seg_of = `DCLSD_SEG_D0;
        4'h1: seg_of = `DCLSD_SEG_D1;
        4'h2: seg_of = `DCLSD_SEG_D2;
        4'h3: seg_of = `DCLSD_SEG_D3;
        4'h4: seg_of = `DCLSD_SEG_D4;
        4'h5: seg_of = `DCLSD_SEG_D5;
        4'h6: seg_of = `DCLSD_SEG_D6;
        4'h7: seg_of = `DCLSD_SEG_D7;
        4'h8: seg_of = `DCLSD_SEG_D8;
        `DCLSD_NINE: seg_of = `DCLSD_SEG_D9;
        default: seg_of = `DCLSD_SEG_ALL_OFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Next decade state after one counted fall
  // ----------------------------------------
  function [3:0] next_digit;
    input [3:0] d;
    begin
      if (d == `DCLSD_NINE) begin
        next_digit = `DCLSD_ZERO;
      end else if (d > `DCLSD_NINE) begin
        // Blank code counts on to digit one
        next_digit = `DCLSD_ONE;
      end else begin
        next_digit = d + `DCLSD_ONE;
      end
    end
  endfunction

  // ----------------------------------------
  // Status word: flag, held digit, live digit
  // ----------------------------------------
  function [31:0] stat_word;
    input flag;
    input [3:0] held;
    input [3:0] live;
    begin
      stat_word = {{`DCLSD_STAT_PAD{1'b0}}, flag, held, live};
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers and count clock edge
  // ----------------------------------------
  reg [`DCLSD_PIN_W-1:0] sync1_reg;
  reg [`DCLSD_PIN_W-1:0] sync2_reg;
  reg clk_prev_reg;
  wire [`DCLSD_PIN_W-1:0] pins_raw;
  wire pin_clk;
  wire pin_enable_n;
  wire pin_clear;
  wire pin_strobe;
  wire clk_fall;
  wire count_step;

  assign pins_raw = {latch_strobe, counter_clear, count_enable_n, count_clk};

  // Two flops per pin; only the second stage is read
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= `DCLSD_SYNC_RST;
      sync2_reg <= `DCLSD_SYNC_RST;
    end else if (ce) begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_clk = sync2_reg[`DCLSD_PIN_CLK];
  assign pin_enable_n = sync2_reg[`DCLSD_PIN_EN_N];
  assign pin_clear = sync2_reg[`DCLSD_PIN_CLR];
  assign pin_strobe = sync2_reg[`DCLSD_PIN_STB];

  // Reset low, so no false fall follows reset
  always @(posedge clk_sys) begin
    if (rst) begin
      clk_prev_reg <= 1'b0;
    end else if (ce) begin
      clk_prev_reg <= pin_clk;
    end
  end

  assign clk_fall = clk_prev_reg & ~pin_clk;
  // Enable delayed like the clock, so no spurious count
  assign count_step = clk_fall & ~pin_enable_n;

  // ----------------------------------------
  // Control register: lamp_check, lamp_blank
  // ----------------------------------------
  reg [`DCLSD_CTRL_W-1:0] ctrl_reg;
  wire lamp_check;
  wire lamp_blank;
  assign lamp_check = ctrl_reg[`DCLSD_CTRL_CHECK];
  assign lamp_blank = ctrl_reg[`DCLSD_CTRL_BLANK];

  // ----------------------------------------
  // Counter, latch and display next values
  // ----------------------------------------
  reg [3:0] count_reg;
  reg [3:0] count_next;
  reg [3:0] latch_reg;
  reg [3:0] latch_next;
  reg [6:0] seg_next;

  always @* begin
    count_next = count_reg;
    if (pin_clear) begin
      count_next = `DCLSD_BLANK;
    end else if (count_step) begin
      count_next = next_digit(count_reg);
    end
  end

  always @* begin
    latch_next = latch_reg;
    if (pin_strobe) begin
      latch_next = count_next;
    end
  end

  always @* begin
    if (lamp_check) begin
      seg_next = `DCLSD_SEG_ALL_ON;
    end else if (lamp_blank) begin
      seg_next = `DCLSD_SEG_ALL_OFF;
    end else begin
      seg_next = seg_of(latch_next);
    end
  end

  // ----------------------------------------
  // Counter, latch, flag and segment registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= `DCLSD_BLANK;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      latch_reg <= `DCLSD_BLANK;
    end else if (ce) begin
      latch_reg <= latch_next;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      terminal_count_flag <= 1'b0;
    end else if (ce) begin
      terminal_count_flag <= (count_next == `DCLSD_NINE);
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      seg_n <= `DCLSD_SEG_ALL_OFF;
    end else if (ce) begin
      seg_n <= seg_next;
    end
  end

  // ----------------------------------------
  // Wishbone slave, one wait state
  // ----------------------------------------
  wire wb_req;
  wire wb_hit_ctrl;
  wire wb_hit_stat;
  wire wb_ctrl_wr;
  reg [31:0] rd_word;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_hit_ctrl = (wb_adr_i == `DCLSD_WB_CTRL);
  assign wb_hit_stat = (wb_adr_i == `DCLSD_WB_STAT);
  assign wb_ctrl_wr = wb_req & wb_we_i & wb_hit_ctrl & wb_sel_i[`DCLSD_SEL_CTRL];

  // Unmapped addresses read as zero
  always @* begin
    rd_word = `DCLSD_DAT_RST;
    if (wb_hit_ctrl) begin
      rd_word = {{(`DCLSD_WB_DW-`DCLSD_CTRL_W){1'b0}}, ctrl_reg};
    end else if (wb_hit_stat) begin
      rd_word = stat_word(terminal_count_flag, latch_reg, count_reg);
    end
  end

  // Ack one cycle after the request, never two in a row while ce is high; ce low holds the ack
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_req;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wb_dat_o <= `DCLSD_DAT_RST;
    end else if (ce && wb_req) begin
      wb_dat_o <= rd_word;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= `DCLSD_CTRL_RST;
    end else if (ce && wb_ctrl_wr) begin
      ctrl_reg <= wb_dat_i[`DCLSD_CTRL_W-1:0];
    end
  end
endmodule

// ===== tb/dclsd_monitor.sv
/* Checker on dclsd_top ports.
   Assumes a bind from the bench. */
`timescale 1ns/100ps
module dclsd_monitor (
  input wire clk_sys, // Clock
  input wire rst, // Reset
  input wire ce, // Run
  input wire count_enable_n, // Hold
  input wire counter_clear, // Clear
  input wire latch_strobe, // Strobe
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Select
  input wire wb_ack_o, // Ack
  input wire [6:0] seg_n, // Segments
  input wire terminal_count_flag // Nine
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence nine_shown;
    latch_strobe[*4] ##0 (seg_n == 7'h10);
  endsequence
  ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack");
  seg_code_a: assert property (seg_n inside {7'h40, 7'h79, 7'h24, 7'h30, 7'h19,
    7'h12, 7'h02, 7'h78, 7'h00, 7'h10, 7'h7f}) else $error("seg");
  nine_seg_a: assert property (nine_shown |-> terminal_count_flag) else $error("nine");
  not_nine_a: assert property ((latch_strobe && !terminal_count_flag)[*4] |->
    seg_n != 7'h10) else $error("nine");
  clear_flag_a: assert property (counter_clear[*5] |-> !terminal_count_flag) else $error("clr");
  hold_count_a: assert property ((count_enable_n && !counter_clear)[*6] |->
    $stable(terminal_count_flag)) else $error("hold");
  latch_hold_a: assert property ((!latch_strobe && !wb_cyc_i)[*4] |->
    $stable(seg_n)) else $error("latch");
endmodule

// ===== tb/dclsd_pulser.sv
/* Pulse source for the counting pin.
   Assumes clk_sys from the bench. */
`timescale 1ns/100ps
module dclsd_pulser (
  input wire clk_sys, // Clock
  output logic count_clk // Idles high
);
  initial count_clk = 1'b1;
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys) count_clk <= 1'b0;
      repeat (3) @(posedge clk_sys);
      count_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== tb/dclsd_tb.sv
/* Bench for dclsd_top.
   Assumes rtl on the include path. */
`timescale 1ns/100ps
module dclsd_tb;
  logic clk_sys = 0, rst = 1, count_enable_n = 0, counter_clear = 0, latch_strobe = 1;
  logic wb_cyc_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic ce = 1'b1;
  wire wb_stb_i = wb_cyc_i;
  wire wb_ack_o, terminal_count_flag, count_clk;
  wire [3:0] wb_sel_i = 4'hf;
  wire [31:0] wb_dat_o;
  wire [6:0] seg_n;
  int num_errors = 0, n_compared = 0;
  logic [6:0] pat [10] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78, 7'h00, 7'h10};
  always #2 clk_sys = ~clk_sys;
  dclsd_top dclsd_top_i(.clk_sys(clk_sys), .rst(rst), .ce(ce), .count_clk(count_clk),
    .count_enable_n(count_enable_n), .counter_clear(counter_clear),
    .latch_strobe(latch_strobe), .seg_n(seg_n), .terminal_count_flag(terminal_count_flag),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  dclsd_pulser dclsd_pulser_i(.clk_sys(clk_sys), .count_clk(count_clk));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys) {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 4'h4, 0);
    chk(q, 32'h0ff);
    @(posedge clk_sys) counter_clear <= 1'b1;
    repeat (6) @(posedge clk_sys);
    counter_clear <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(seg_n, 7'h7f);
    for (int i = 1; i < 11; i++) begin
      dclsd_pulser_i.pulses(1);
      bus(0, 4'h4, 0);
      chk(q, (i % 10) * 17 + (i == 9) * 256);
      chk(seg_n, pat[i % 10]);
    end
    count_enable_n <= 1'b1;
    dclsd_pulser_i.pulses(2);
    bus(0, 4'h4, 0);
    chk(q, 32'h0);
    count_enable_n <= 1'b0;
    latch_strobe <= 1'b0;
    dclsd_pulser_i.pulses(1);
    bus(0, 4'h4, 0);
    chk(q, 32'h01);
    chk(seg_n, 7'h40);
    latch_strobe <= 1'b1;
    bus(1, 4'h0, 2);
    repeat (3) @(posedge clk_sys);
    chk(seg_n, 7'h7f);
    bus(1, 4'h0, 3);
    repeat (3) @(posedge clk_sys);
    chk(seg_n, 7'h00);
    ce <= 1'b0;
    dclsd_pulser_i.pulses(1);
    ce <= 1'b1;
    bus(0, 4'h4, 0);
    chk(q, 32'h011);
    bus(0, 4'hc, 0);
    chk(q, 32'h0);
    end_of_test;
  end
  // Watchdog
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
bind dclsd_top dclsd_monitor dclsd_monitor_i(.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .count_enable_n(count_enable_n), .counter_clear(counter_clear),
  .latch_strobe(latch_strobe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .seg_n(seg_n), .terminal_count_flag(terminal_count_flag));
